// File: dv/arp_host_model.sv
// host-side bus master model for the result read port
`timescale 1ns/1ns
module arp_host_model (
  input  wire logic        clk_i,   // clock
  output logic             cs_n_o,  // chip select
  output logic             rd_n_o,  // read strobe
  output logic             wr_n_o,  // write strobe
  output logic [2:0]       addr_o,  // address pins
  output logic [15:0]      bus_o,   // bus towards the port
  input  wire logic [15:0] bus_i,   // port data
  input  wire logic        oe_i     // port drive enable
);
  initial
  begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 3'h0;
    bus_o  = 16'h5a5a;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one read; word sampled after the strobe has been low three cycles
  task automatic rd(input logic [2:0] a, input logic sel, output logic [15:0] d,
                    output logic oe);
    @(negedge clk_i);
    addr_o = a;
    cs_n_o = ~sel;
    rd_n_o = 1'b0;
    repeat (3) @(negedge clk_i);
    d = bus_i;
    oe = oe_i;
    rd_n_o = 1'b1;
    @(negedge clk_i);
    cs_n_o = 1'b1;
  endtask

  task automatic wr(input logic [7:0] b);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    bus_o  = {8'h00, b};
    @(negedge clk_i);
    wr_n_o = 1'b1;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    // released bus shows a changed pattern, not the last value
    bus_o  = ~bus_o;
  endtask
endmodule // arp_host_model

// File: dv/testbench.sv
// self-checking bench for the result read port
`timescale 1ns/1ns
module testbench;
  logic                   clk_i;
  logic                   rst_i;
  logic                   tag_en;
  logic                   narrow;
  logic                   rst_pin;
  logic [2:0]             hold_n;
  logic [2:0]             hold_o;
  logic                   conv_rst;
  logic [5:0]             res_vld;
  arp_pkg::arp_res_bank_t res_dat;
  logic                   cs_n;
  logic                   rd_n;
  logic                   wr_n;
  logic [2:0]             addr;
  logic [15:0]            bus_h;
  logic [15:0]            bus_d;
  logic                   oe;
  logic [15:0]            d;
  logic                   o;
  logic [15:0]            v;
  int                     errors;
  int                     num_checks;

  arp_read_port u_arp_read_port (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .output_data_pins_i(bus_h), .output_data_pins_o(bus_d),
    .output_data_pins_oe_o(oe), .addr_sel_bit0_i(addr[0]), .addr_sel_bit1_i(addr[1]),
    .addr_sel_bit2_i(addr[2]), .tag_en_i(tag_en), .narrow_i(narrow),
    .reset_pin_i(rst_pin), .hold_pair_a_n_i(hold_n[0]), .hold_pair_b_n_i(hold_n[1]),
    .hold_pair_c_n_i(hold_n[2]), .res_valid_i(res_vld), .res_data_i(res_dat),
    .hold_pair_a_n_o(hold_o[0]), .hold_pair_b_n_o(hold_o[1]),
    .hold_pair_c_n_o(hold_o[2]), .conv_reset_o(conv_rst));

  arp_host_model u_host (
    .clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr),
    .bus_o(bus_h), .bus_i(bus_d), .oe_i(oe));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] val(input int c, input int r);
    return 16'(r * 4096 + c * 273 + 66);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic push(input logic [5:0] m, input int r);
    @(negedge clk_i);
    for (int c = 0; c < 6; c++) res_dat[c] = val(c, r);
    res_vld = m;
    @(negedge clk_i);
    res_vld = 6'h00;
  endtask

  task automatic soft_reset();
    @(negedge clk_i);
    rst_pin = 1'b1;
    @(negedge clk_i);
    rst_pin = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_direct();
    push(6'h3f, 2);
    tag_en = 1'b1;
    for (int c = 0; c < 6; c++)
    begin
      u_host.rd(3'(c), 1'b1, d, o);
      chk(d, val(c, 2));
      chk({15'h0, o}, 16'h1);
    end
    narrow = 1'b1;
    v = val(3, 2);
    u_host.rd(3'h3, 1'b1, d, o);
    chk(d, {2{v[7:0]}});
    u_host.rd(3'h3, 1'b1, d, o);
    chk(d, {2{v[15:8]}});
    narrow = 1'b0;
    tag_en = 1'b0;
    u_host.rd(3'h0, 1'b0, d, o);
    chk({15'h0, o}, 16'h0);
  endtask

  task automatic t_cycle();
    soft_reset();
    push(6'h3f, 7);
    for (int i = 0; i < 7; i++)
    begin
      u_host.rd(3'h6, 1'b1, d, o);
      chk(d, val(i % 6, 7));
    end
    // a result that lands mid-read must wait for the strobe to rise
    fork
      u_host.rd(3'h0, 1'b1, d, o);
      begin
        @(negedge clk_i);
        push(6'h01, 8);
      end
    join
    chk(d, val(0, 7));
    u_host.rd(3'h0, 1'b1, d, o);
    chk(d, val(0, 8));
  endtask

  task automatic t_fifo_tag();
    soft_reset();
    push(6'h02, 5);
    push(6'h10, 5);
    tag_en = 1'b1;
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, 16'h8009);
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, val(1, 5));
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, 16'h800c);
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, val(4, 5));
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, 16'h0000);
    // second word of the empty tagged pair keeps the phase count in step
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, 16'h0000);
    narrow = 1'b1;
    push(6'h04, 6);
    v = val(2, 6);
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, {2{1'b1, 3'h2, v[3:0]}});
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, {2{v[7:0]}});
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, {2{v[15:8]}});
    narrow = 1'b0;
    tag_en = 1'b0;
  endtask

  task automatic t_overflow();
    soft_reset();
    for (int r = 0; r < 4; r++) push(6'h3f, r);
    for (int r = 1; r < 4; r++)
      for (int c = 0; c < 6; c++)
      begin
        u_host.rd(3'h7, 1'b1, d, o);
        chk(d, val(c, r));
      end
    u_host.rd(3'h7, 1'b1, d, o);
    chk(d, 16'h0000);
  endtask

  task automatic t_ctrl();
    u_host.wr(8'h8f);
    push(6'h20, 3);
    u_host.rd(3'h0, 1'b1, d, o);
    chk(d, 16'h800d);
    u_host.rd(3'h0, 1'b1, d, o);
    chk(d, val(5, 3));
    u_host.wr(8'h02);
    @(negedge clk_i);
    chk({13'h0, hold_o}, 16'h0005);
    repeat (8) @(negedge clk_i);
    chk({13'h0, hold_o}, 16'h0007);
    hold_n[0] = 1'b0;
    @(negedge clk_i);
    chk({13'h0, hold_o}, 16'h0006);
    hold_n[0] = 1'b1;
    push(6'h20, 4);
    u_host.wr(8'h08);
    @(negedge clk_i);
    chk({15'h0, conv_rst}, 16'h1);
    repeat (8) @(negedge clk_i);
    u_host.rd(3'h0, 1'b1, d, o);
    chk(d, 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    rst_i = 1'b1;
    tag_en = 1'b0;
    narrow = 1'b0;
    rst_pin = 1'b0;
    hold_n = 3'h7;
    res_vld = 6'h00;
    res_dat = '0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_direct();
    t_cycle();
    t_fifo_tag();
    t_overflow();
    t_ctrl();
    complete_run();
  end
endmodule // testbench

// File: src/arp_edge.sv
// rising-edge detector for a bus strobe
`timescale 1ns/1ns
module arp_edge #(
  parameter logic IDLE = 1'b1
) (
  input  wire logic clk_i,   // clock
  input  wire logic rst_i,   // sync reset
  input  wire logic ce_i,    // clock enable
  input  wire logic sig_i,   // strobe level
  output logic      rise_o   // high in the cycle the strobe rose
);

  logic prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= IDLE;
    else if (ce_i)
      prev_q <= sig_i;
  end

  assign rise_o = sig_i & ~prev_q;

endmodule // arp_edge

// File: src/arp_fifo.sv
// shift-down result store ordered by arrival, oldest dropped when full
`timescale 1ns/1ns
module arp_fifo #(
  parameter int unsigned DEPTH = arp_pkg::FIFO_DEPTH,
  parameter int unsigned CNT_W = arp_pkg::CNT_W
) (
  input  wire logic                  clk_i,    // clock
  input  wire logic                  rst_i,    // sync reset
  input  wire logic                  ce_i,     // clock enable
  input  wire logic                  clr_i,    // empty the store
  input  wire logic [5:0]            push_i,   // per-channel new result
  input  wire arp_pkg::arp_res_bank_t data_i,  // results by channel
  input  wire logic                  pop_i,    // head read completed
  output arp_pkg::arp_entry_t        head_o,   // oldest entry, zero if empty
  output logic [CNT_W-1:0]           count_o   // entries held
);

  arp_pkg::arp_entry_t mem_q [DEPTH];
  arp_pkg::arp_entry_t mem_d [DEPTH];
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    cnt_d;

  always_comb
  begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (pop_i && cnt_d != '0)
    begin
      for (int k = 0; k < DEPTH - 1; k++)
        mem_d[k] = mem_d[k+1];
      mem_d[DEPTH-1] = '0;
      cnt_d = cnt_d - 1'b1;
    end
    // simultaneous arrivals are stored in channel order
    for (int ch = 0; ch < arp_pkg::NUM_CH; ch++)
    begin
      if (push_i[ch])
      begin
        if (cnt_d == CNT_W'(DEPTH))
        begin
          for (int k = 0; k < DEPTH - 1; k++)
            mem_d[k] = mem_d[k+1];
          cnt_d = cnt_d - 1'b1;
        end
        mem_d[cnt_d] = '{valid: 1'b1, chan: 3'(ch), data: data_i[ch]};
        cnt_d = cnt_d + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && clr_i))
    begin
      cnt_q <= '0;
      for (int k = 0; k < DEPTH; k++)
        mem_q[k] <= '0;
    end
    else if (ce_i)
    begin
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  assign head_o  = (cnt_q != '0) ? mem_q[0] : '0;
  assign count_o = cnt_q;

endmodule // arp_fifo

// File: src/arp_pkg.sv
// shared constants and carrier types for the result read port
package arp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int unsigned NUM_CH      = 6;
  localparam int unsigned CH_W        = 3;
  localparam int unsigned RES_W       = 16;
  localparam int unsigned FIFO_PER_CH = 3;
  localparam int unsigned FIFO_DEPTH  = NUM_CH * FIFO_PER_CH;
  localparam int unsigned CNT_W       = 5;

  ////////////////////////////////////////////////////////////////////////////
  // address codes and tag layout
  localparam logic [2:0]  CH_FIRST    = 3'h0;
  localparam logic [2:0]  CH_LAST     = 3'h5;
  localparam logic [11:0] TAG_PREFIX  = 12'h800;
  localparam logic [1:0]  PH_FIRST    = 2'h0;
  localparam logic [1:0]  WORDS_ONE   = 2'h1;
  localparam logic [1:0]  WORDS_TWO   = 2'h2;
  localparam logic [1:0]  WORDS_THREE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // control word fields
  localparam int unsigned CW_MODE_BIT = 7;
  localparam int unsigned CW_TAG_BIT  = 3;
  localparam int unsigned CW_RST_BIT  = 3;
  localparam int unsigned CW_HA_BIT   = 2;
  localparam int unsigned CW_HB_BIT   = 1;
  localparam int unsigned CW_HC_BIT   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: a commanded hold is held low at least this long
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned HOLD_LOW_NS   = 20;
  localparam logic [1:0]  HOLD_LOW_CYC  =
    2'((HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef logic [NUM_CH-1:0][RES_W-1:0] arp_res_bank_t;

  typedef struct packed {
    logic             valid;
    logic [CH_W-1:0]  chan;
    logic [RES_W-1:0] data;
  } arp_entry_t;

  typedef struct packed {
    logic       tag_en;
    logic [2:0] addr;
  } arp_cfg_t;

  typedef struct packed {
    logic rst;
    logic hold_a;
    logic hold_b;
    logic hold_c;
  } arp_cmd_t;

  localparam arp_cfg_t CFG_RESET = '0;
  localparam arp_cmd_t CMD_RESET = '0;

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_CYCLE,
    MODE_FIFO
  } arp_mode_t;

endpackage

// File: src/arp_read_port.sv
// parallel result read port: direct, cycle and fifo read-out, control word
`timescale 1ns/1ns
module arp_read_port #(
  parameter int unsigned FIFO_DEPTH = arp_pkg::FIFO_DEPTH
) (
  input  wire logic                  clk_i,                  // converter clock
  input  wire logic                  rst_i,                  // sync reset
  input  wire logic                  ce_i,                   // clock enable
  input  wire logic                  cs_n_i,                 // chip select
  input  wire logic                  rd_n_i,                 // read strobe
  input  wire logic                  wr_n_i,                 // write strobe
  input  wire logic [15:0]           output_data_pins_i,     // bus in
  output logic [15:0]                output_data_pins_o,     // bus out
  output logic                       output_data_pins_oe_o,  // bus drive
  input  wire logic                  addr_sel_bit0_i,        // address pin 0
  input  wire logic                  addr_sel_bit1_i,        // address pin 1
  input  wire logic                  addr_sel_bit2_i,        // address pin 2
  input  wire logic                  tag_en_i,               // tag enable pin
  input  wire logic                  narrow_i,               // 8-bit bus pin
  input  wire logic                  reset_pin_i,            // reset pin
  input  wire logic                  hold_pair_a_n_i,        // hold pin A
  input  wire logic                  hold_pair_b_n_i,        // hold pin B
  input  wire logic                  hold_pair_c_n_i,        // hold pin C
  input  wire logic [5:0]            res_valid_i,            // new result pulse
  input  wire arp_pkg::arp_res_bank_t res_data_i,            // new results
  output logic                       hold_pair_a_n_o,        // hold to core A
  output logic                       hold_pair_b_n_o,        // hold to core B
  output logic                       hold_pair_c_n_o,        // hold to core C
  output logic                       conv_reset_o            // reset to core
);

  ////////////////////////////////////////////////////////////////////////////
  // strobes and control word
  logic                wr_rise;
  logic                rd_rise;
  logic                wr_take;
  logic                done;
  arp_pkg::arp_cfg_t   cfg_q;
  arp_pkg::arp_cmd_t   cmd_q;
  logic [1:0]          cmd_cnt_q;
  logic [7:0]          cw;
  logic                clr;

  arp_edge #(.IDLE(1'b1)) u_wr_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sig_i  (wr_n_i),
    .rise_o (wr_rise)
  );

  arp_edge #(.IDLE(1'b1)) u_rd_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sig_i  (rd_n_i),
    .rise_o (rd_rise)
  );

  assign cw      = output_data_pins_i[7:0];
  assign wr_take = ce_i && wr_rise && !cs_n_i;
  assign done    = ce_i && rd_rise && !cs_n_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_q <= arp_pkg::CFG_RESET;
    else if (wr_take && cw[arp_pkg::CW_MODE_BIT])
      cfg_q <= '{tag_en: cw[arp_pkg::CW_TAG_BIT], addr: cw[2:0]};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_q     <= arp_pkg::CMD_RESET;
      cmd_cnt_q <= '0;
    end
    else if (wr_take && !cw[arp_pkg::CW_MODE_BIT])
    begin
      cmd_q     <= '{rst:    cw[arp_pkg::CW_RST_BIT],
                     hold_a: cw[arp_pkg::CW_HA_BIT],
                     hold_b: cw[arp_pkg::CW_HB_BIT],
                     hold_c: cw[arp_pkg::CW_HC_BIT]};
      cmd_cnt_q <= arp_pkg::HOLD_LOW_CYC;
    end
    else if (ce_i && cmd_cnt_q != '0)
      cmd_cnt_q <= cmd_cnt_q - 1'b1;
    else if (ce_i)
      cmd_q <= arp_pkg::CMD_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective mode: pins ORed with the control word
  logic [2:0]          addr_eff;
  logic                tag_eff;
  logic [2:0]          dir_ch;
  arp_pkg::arp_mode_t  mode;

  assign addr_eff = {addr_sel_bit2_i, addr_sel_bit1_i, addr_sel_bit0_i} | cfg_q.addr;
  assign tag_eff  = tag_en_i | cfg_q.tag_en;
  assign clr             = reset_pin_i | cmd_q.rst;
  assign conv_reset_o    = clr;
  assign hold_pair_a_n_o = hold_pair_a_n_i & ~cmd_q.hold_a;
  assign hold_pair_b_n_o = hold_pair_b_n_i & ~cmd_q.hold_b;
  assign hold_pair_c_n_o = hold_pair_c_n_i & ~cmd_q.hold_c;

  // codes 0..5 direct, 6 cycle, 7 fifo
  always_comb
  begin
    case (addr_eff)
      3'h6:    mode = arp_pkg::MODE_CYCLE;
      3'h7:    mode = arp_pkg::MODE_FIFO;
      default: mode = arp_pkg::MODE_DIRECT;
    endcase
  end
  assign dir_ch = (addr_eff > arp_pkg::CH_LAST) ? arp_pkg::CH_FIRST : addr_eff;

  ////////////////////////////////////////////////////////////////////////////
  // result capture, deferred while the strobe is low
  logic [5:0]              pend_vld_q;
  arp_pkg::arp_res_bank_t  pend_dat_q;
  logic [5:0]              push_vec;
  arp_pkg::arp_res_bank_t  push_dat;
  arp_pkg::arp_res_bank_t  res_q;
  logic [5:0]              have_q;

  always_comb
  begin
    push_vec = rd_n_i ? (res_valid_i | pend_vld_q) : 6'h00;
    for (int ch = 0; ch < arp_pkg::NUM_CH; ch++)
      push_dat[ch] = res_valid_i[ch] ? res_data_i[ch] : pend_dat_q[ch];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && clr))
      pend_vld_q <= '0;
    else if (ce_i && !rd_n_i)
      pend_vld_q <= pend_vld_q | res_valid_i;
    else if (ce_i)
      pend_vld_q <= '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_dat_q <= '0;
    else if (ce_i && !rd_n_i)
      for (int ch = 0; ch < arp_pkg::NUM_CH; ch++)
        if (res_valid_i[ch])
          pend_dat_q[ch] <= res_data_i[ch];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && clr))
    begin
      res_q  <= '0;
      have_q <= '0;
    end
    else if (ce_i)
    begin
      have_q <= have_q | push_vec;
      for (int ch = 0; ch < arp_pkg::NUM_CH; ch++)
        if (push_vec[ch])
          res_q[ch] <= push_dat[ch];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo, read phase and cycle pointer
  logic [1:0]                 phase_q;
  logic [1:0]                 n_words;
  logic                       last;
  logic [2:0]                 rr_q;
  arp_pkg::arp_entry_t        head;
  logic [arp_pkg::CNT_W-1:0]  fifo_cnt;
  logic                       fifo_empty;

  assign fifo_empty = (fifo_cnt == '0);

  // fifo mode pops in arrival order
  arp_fifo #(.DEPTH(FIFO_DEPTH), .CNT_W(arp_pkg::CNT_W)) u_fifo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .clr_i   (clr),
    .push_i  (push_vec),
    .data_i  (push_dat),
    .pop_i   (done && last && mode == arp_pkg::MODE_FIFO),
    .head_o  (head),
    .count_o (fifo_cnt)
  );

  always_comb
  begin
    if (mode == arp_pkg::MODE_DIRECT || !tag_eff)
      n_words = narrow_i ? arp_pkg::WORDS_TWO : arp_pkg::WORDS_ONE;
    else
      n_words = narrow_i ? arp_pkg::WORDS_THREE : arp_pkg::WORDS_TWO;
  end
  assign last = (phase_q == n_words - 2'h1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && clr))
      phase_q <= arp_pkg::PH_FIRST;
    else if (done)
      phase_q <= last ? arp_pkg::PH_FIRST : phase_q + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && clr))
      rr_q <= arp_pkg::CH_FIRST;
    else if (done && last && mode == arp_pkg::MODE_CYCLE)
      rr_q <= (rr_q == arp_pkg::CH_LAST) ? arp_pkg::CH_FIRST : rr_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output word
  arp_pkg::arp_entry_t cur;
  logic [15:0]         word_d;
  logic [15:0]         data_q;
  logic [7:0]          byte_sel;
  logic [15:0]         dir_res;

  assign dir_res = res_q[dir_ch];

  always_comb
  begin
    case (mode)
      arp_pkg::MODE_CYCLE: cur = '{valid: have_q[rr_q], chan: rr_q, data: res_q[rr_q]};
      arp_pkg::MODE_FIFO:  cur = head;
      default:             cur = '{valid: 1'b1, chan: dir_ch, data: dir_res};
    endcase
  end

  always_comb
  begin
    byte_sel = cur.data[7:0];
    word_d   = cur.data;
    if (mode != arp_pkg::MODE_DIRECT && tag_eff)
    begin
      case (phase_q)
        2'h0:    byte_sel = {cur.valid, cur.chan, cur.data[3:0]};
        2'h1:    byte_sel = cur.data[7:0];
        default: byte_sel = cur.data[15:8];
      endcase
      if (phase_q == arp_pkg::PH_FIRST)
        word_d = {arp_pkg::TAG_PREFIX, cur.valid, cur.chan};
    end
    else if (phase_q != arp_pkg::PH_FIRST)
      byte_sel = cur.data[15:8];
    if (narrow_i)
      word_d = {byte_sel, byte_sel};
    if (mode == arp_pkg::MODE_FIFO && fifo_empty)
      word_d = '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_q <= '0;
    else if (ce_i)
      data_q <= word_d;
  end

  assign output_data_pins_oe_o = !cs_n_i && !rd_n_i;
  assign output_data_pins_o    = data_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_final_read;
    done && last;
  endsequence

  property p_oe_idle;
    (cs_n_i || rd_n_i) |-> !output_data_pins_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pins driven outside a selected read");

  property p_clear_all;
    (ce_i && clr) |=> (fifo_cnt == '0 && res_q == '0 && rr_q == arp_pkg::CH_FIRST);
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("reset left results or pointer behind");

  property p_rr_wrap;
    s_final_read ##0 (mode == arp_pkg::MODE_CYCLE && rr_q == arp_pkg::CH_LAST)
      |=> rr_q == arp_pkg::CH_FIRST;
  endproperty
  a_rr_wrap: assert property (p_rr_wrap)
    else $error("cycle pointer did not wrap to first channel");

  property p_rr_step;
    s_final_read ##0 (mode == arp_pkg::MODE_CYCLE && rr_q < arp_pkg::CH_LAST && !clr)
      |=> rr_q == $past(rr_q) + 3'h1;
  endproperty
  a_rr_step: assert property (p_rr_step)
    else $error("cycle pointer did not step by one");

  property p_phase_back;
    s_final_read ##0 !clr |=> phase_q == arp_pkg::PH_FIRST;
  endproperty
  a_phase_back: assert property (p_phase_back)
    else $error("read phase not restarted after final word");

  property p_fifo_pop;
    s_final_read ##0 (mode == arp_pkg::MODE_FIFO && !fifo_empty && push_vec == '0 && !clr)
      |=> fifo_cnt == $past(fifo_cnt) - 1'b1;
  endproperty
  a_fifo_pop: assert property (p_fifo_pop)
    else $error("head read did not remove one entry");

  property p_hold_off;
    (ce_i && !rd_n_i && !clr) |=> $stable(res_q);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("result latched while strobe low");

  property p_empty_zero;
    (ce_i && mode == arp_pkg::MODE_FIFO && fifo_empty) |=> output_data_pins_o == '0;
  endproperty
  a_empty_zero: assert property (p_empty_zero)
    else $error("empty fifo read not zero");

  property p_tag_word;
    (ce_i && mode != arp_pkg::MODE_DIRECT && tag_eff && !narrow_i
      && phase_q == arp_pkg::PH_FIRST && !(mode == arp_pkg::MODE_FIFO && fifo_empty))
      |=> output_data_pins_o[15:4] == arp_pkg::TAG_PREFIX;
  endproperty
  a_tag_word: assert property (p_tag_word)
    else $error("tag word prefix wrong");

  property p_direct_full;
    (ce_i && mode == arp_pkg::MODE_DIRECT && !narrow_i) |=> output_data_pins_o == $past(dir_res);
  endproperty
  a_direct_full: assert property (p_direct_full)
    else $error("direct read did not give selected result");

  property p_narrow_lanes;
    (ce_i && narrow_i) |=> output_data_pins_o[15:8] == output_data_pins_o[7:0];
  endproperty
  a_narrow_lanes: assert property (p_narrow_lanes)
    else $error("narrow byte not on both lanes");

endmodule // arp_read_port
